// ---- rpps_far_model.sv ----
// Far side model: outside pin drivers and peripheral outputs
`timescale 1ns/1ps
`default_nettype none
module rpps_far_model (
    input wire logic clk_sys_in,
    input wire logic step_in,
    input wire logic [31:0] pin_drv_in,
    input wire logic [31:0] pin_oe_in,
    output logic [31:0] pin_lvl_out,
    output logic [22:0] periph_lvl_out,
    output logic [31:0] ext_lvl_out
);
    int seed = 6699;
    initial begin
        ext_lvl_out = 32'h0000_0000;
        periph_lvl_out = 23'h00_0000;
    end
    // New levels only on request, so results can settle
    always @(posedge clk_sys_in) begin
        if (step_in) begin
            ext_lvl_out <= $random(seed);
            periph_lvl_out <= 23'($random(seed));
        end
    end
    // pad driven by device wins over outside
    assign pin_lvl_out = (pin_drv_in & pin_oe_in) | (ext_lvl_out & ~pin_oe_in);
endmodule
`default_nettype wire

// ---- rpps_pin_select.sv ----
// Remappable peripheral pin select: input and output mapping with write lock
//
// How it works
// (R1) Each peripheral input takes its selected pin
// (R2) Two 6-bit selector fields per input register
// (R3) Selectors limited to implemented pin range
// (R4) Selectors for irq, capture, fault, SPI, timer, UART
// (R5) Each pin driven by its selected function
// (R6) Two 5-bit code fields per output register
// (R7) Null code leaves pin undriven
// (R8) Codes 1-12: comparators, UART, SPI outputs
// (R9) Codes 18-22 compare, 29 pulse, 30 comparator3
// (R10) Reset puts null function on every pin
// (R11) UART RTS codes also carry infrared bit-clock
// (R12) One selector per input and pin blocks contention
// (R13) Pins and outputs may fan out freely
// (R14) Selector encoding addresses 32 pins
// (R15) Variant sets: 28-pin 15, 44-pin 25
// (R16) Input and output maps are independent
// (R17) Locked writes complete but change nothing
// (R18) Software unlocks by 46h then 57h key
// (R19) Reset: inputs all ones, outputs zero
// (R20) Shadow copies detect unexpected map change
// (R21) Codes 13 to 17 behave as null
// (R22) Unimplemented selected pin feeds low
`timescale 1ns/1ps
`default_nettype none
module rpps_pin_select (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic variant_44_in,
    input wire logic osc_ctl_wr_in,
    input wire logic [7:0] osc_ctl_wdata_in,
    input wire logic in_map_wr_in,
    input wire logic [3:0] in_map_idx_in,
    input wire logic [15:0] in_map_wdata_in,
    input wire logic out_map_wr_in,
    input wire logic [3:0] out_map_idx_in,
    input wire logic [15:0] out_map_wdata_in,
    input wire logic [31:0] remap_pin_in,
    input wire logic [22:0] periph_out_in,
    input wire logic map_fault_inject_in,
    output logic [22:0] periph_in_out,
    output logic [31:0] remap_pin_out,
    output logic [31:0] remap_pin_oe_out,
    output logic map_write_lock_out,
    output logic config_mismatch_out,
    output logic [15:0] in_map_rdata_out,
    output logic [15:0] out_map_rdata_out
);
    // ****************************************
    // Pin synchronisers and variant strap
    // ****************************************
    logic [31:0] pin_meta_q, pin_meta_d, pin_sync_q, pin_sync_d;
    logic var44_meta_q, var44_meta_d, var44_q, var44_d;
    logic [31:0] impl_q, impl_d;
    // ****************************************
    // Mapping state
    // ****************************************
    // (R4) One selector per listed input
    logic [5:0] in_sel_q [rpps_pkg::NUM_INPUTS];
    logic [5:0] in_sel_d [rpps_pkg::NUM_INPUTS];
    logic [5:0] in_shd_q [rpps_pkg::NUM_INPUTS];
    logic [4:0] out_sel_q [rpps_pkg::NUM_PINS];
    logic [4:0] out_sel_d [rpps_pkg::NUM_PINS];
    logic [4:0] out_shd_q [rpps_pkg::NUM_PINS];
    logic lock_q, lock_d, mism_q, mism_d, wr_ok;
    rpps_pkg::rpps_unl_state_t unl_q, unl_d;
    logic [22:0] pin_in_d;
    logic [31:0] pin_out_d, pin_oe_d;
    logic [22:0] periph_in_q;
    logic [31:0] pin_out_q, pin_oe_q;
    logic [15:0] in_rd_d, in_rd_q, out_rd_d, out_rd_q;

    // Output function decoding, used once per pin
    function automatic logic [1:0] out_fn(input logic [4:0] code, input logic [22:0] src);
        logic [1:0] r;
        r = 2'b00;
        // (R8) Codes one to twelve
        // (R11) RTS codes carry infrared bit-clock
        if (code >= rpps_pkg::FN_CMP1 && code <= rpps_pkg::FN_SPI2_SS) begin
            r = {1'b1, src[code - 5'h01]};
        // (R9) Compare outputs
        end else if (code >= rpps_pkg::FN_CMP_OC1 && code < rpps_pkg::FN_CMP_OC1 + 5'h05) begin
            r = {1'b1, src[5'd12 + (code - rpps_pkg::FN_CMP_OC1)]};
        end else if (code == rpps_pkg::FN_CTPULSE) begin
            r = {1'b1, src[17]};
        end else if (code == rpps_pkg::FN_CMP3) begin
            r = {1'b1, src[18]};
        end
        // (R7) Null and unlisted codes drive nothing
        // (R21) Codes 13 to 17 drive nothing
        return r;
    endfunction

    always_comb begin
        pin_meta_d = remap_pin_in;
        pin_sync_d = pin_meta_q;
        // The strap is a pin too, so it is synchronised like the others
        var44_meta_d = variant_44_in;
        var44_d = var44_meta_q;
        // (R15) Implemented pin set
        impl_d = var44_q ? rpps_pkg::PINS_44 : rpps_pkg::PINS_28;
    end

    // ****************************************
    // Lock sequencer
    // ****************************************
    always_comb begin
        unl_d = unl_q;
        lock_d = lock_q;
        if (osc_ctl_wr_in) begin
            // (R18) Key sequence then lock write
            // A wrong byte other than a repeated 46h drops back to idle, so such a stray write cancels the keys
            case (unl_q)
                rpps_pkg::UNL_IDLE: begin
                    unl_d = (osc_ctl_wdata_in == rpps_pkg::UNLOCK_KEY1) ?
                        rpps_pkg::UNL_KEY1 : rpps_pkg::UNL_IDLE;
                end
                rpps_pkg::UNL_KEY1: begin
                    unl_d = (osc_ctl_wdata_in == rpps_pkg::UNLOCK_KEY2) ? rpps_pkg::UNL_OPEN :
                        (osc_ctl_wdata_in == rpps_pkg::UNLOCK_KEY1) ?
                        rpps_pkg::UNL_KEY1 : rpps_pkg::UNL_IDLE;
                end
                rpps_pkg::UNL_OPEN: begin
                    lock_d = osc_ctl_wdata_in[rpps_pkg::LOCK_BIT];
                    unl_d = rpps_pkg::UNL_IDLE;
                end
                default: unl_d = rpps_pkg::UNL_IDLE;
            endcase
        end
    end

    // ****************************************
    // Map registers
    // ****************************************
    // A lock set in the same cycle as a map write does not stop that write
    // (R17) Locked writes are dropped silently
    assign wr_ok = !lock_q;

    always_comb begin
        for (int i = 0; i < rpps_pkg::NUM_INPUTS; i++) begin
            in_sel_d[i] = in_sel_q[i];
            // (R2) Even field low byte, odd field high byte
            if (in_map_wr_in && wr_ok && in_map_idx_in == 4'(i / 2)) begin
                in_sel_d[i] = (i % 2 == 0) ? in_map_wdata_in[5:0] : in_map_wdata_in[13:8];
            end
        end
        for (int p = 0; p < rpps_pkg::NUM_PINS; p++) begin
            out_sel_d[p] = out_sel_q[p];
            // (R6) Two code fields per register
            if (out_map_wr_in && wr_ok && out_map_idx_in == 4'(p / 2)) begin
                out_sel_d[p] = (p % 2 == 0) ? out_map_wdata_in[4:0] : out_map_wdata_in[12:8];
            end
        end
    end

    // ****************************************
    // Shadow monitor
    // ****************************************
    // Shadows load with every legal write, so only a disturbed cell or the test hook trips it
    always_comb begin
        // (R20) Shadow compare raises mismatch
        mism_d = mism_q | map_fault_inject_in;
        for (int i = 0; i < rpps_pkg::NUM_INPUTS; i++) begin
            if (in_sel_q[i] != in_shd_q[i]) begin
                mism_d = 1'b1;
            end
        end
        for (int p = 0; p < rpps_pkg::NUM_PINS; p++) begin
            if (out_sel_q[p] != out_shd_q[p]) begin
                mism_d = 1'b1;
            end
        end
    end

    // ****************************************
    // Readback
    // ****************************************
    always_comb begin
        in_rd_d = 16'h0000;
        out_rd_d = 16'h0000;
        for (int i = 0; i < rpps_pkg::NUM_INPUTS; i++) begin
            if (in_map_idx_in == 4'(i / 2)) begin
                if (i % 2 == 0) begin
                    in_rd_d[5:0] = in_sel_q[i];
                end else begin
                    in_rd_d[13:8] = in_sel_q[i];
                end
            end
        end
        for (int p = 0; p < rpps_pkg::NUM_PINS; p++) begin
            if (out_map_idx_in == 4'(p / 2)) begin
                if (p % 2 == 0) begin
                    out_rd_d[4:0] = out_sel_q[p];
                end else begin
                    out_rd_d[12:8] = out_sel_q[p];
                end
            end
        end
    end

    // ****************************************
    // Routing
    // ****************************************
    // Inputs read only the synchronised pins, never the raw pads
    // (R1) Each input reads its own selector
    // (R13) One pin feeds many inputs
    for (genvar gi = 0; gi < rpps_pkg::NUM_INPUTS; gi++) begin : g_in
        // (R3) Out-of-range selector reads low
        // (R14) Five low bits address 32 pins
        // (R22) Unimplemented pin reads low
        assign pin_in_d[gi] = (in_sel_q[gi] < 6'(rpps_pkg::NUM_PINS) &&
            impl_q[in_sel_q[gi][4:0]]) ? pin_sync_q[in_sel_q[gi][4:0]] : 1'b0;
    end

    // (R13) One output may drive many pins
    for (genvar gp = 0; gp < rpps_pkg::NUM_PINS; gp++) begin : g_out
        logic [1:0] fn_hit;
        // (R5) Each pin follows its own code
        // (R12) One code per pin, no contention
        assign fn_hit = out_fn(out_sel_q[gp], periph_out_in);
        // (R15) Unimplemented pins never drive
        assign pin_oe_d[gp] = fn_hit[1] & impl_q[gp];
        assign pin_out_d[gp] = fn_hit[0] & impl_q[gp];
    end

    // ****************************************
    // Registers
    // ****************************************
    // Synchronisers carry no reset: they only follow the pins
    always_ff @(posedge clk_sys_in) begin
        pin_meta_q <= pin_meta_d;
        pin_sync_q <= pin_sync_d;
        var44_meta_q <= var44_meta_d;
        var44_q <= var44_d;
    end

    // Lock sequencer and mismatch flag
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            lock_q <= 1'b0;
            mism_q <= 1'b0;
            unl_q <= rpps_pkg::UNL_IDLE;
        end else begin
            lock_q <= lock_d;
            mism_q <= mism_d;
            unl_q <= unl_d;
        end
    end

    // Map selectors and their shadows
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            // (R19) Inputs select pin 63, tied low
            // (R10) Every pin takes the null code
            for (int i = 0; i < rpps_pkg::NUM_INPUTS; i++) begin
                in_sel_q[i] <= rpps_pkg::IN_SEL_RESET;
                in_shd_q[i] <= rpps_pkg::IN_SEL_RESET;
            end
            for (int p = 0; p < rpps_pkg::NUM_PINS; p++) begin
                out_sel_q[p] <= rpps_pkg::OUT_SEL_RESET;
                out_shd_q[p] <= rpps_pkg::OUT_SEL_RESET;
            end
        end else begin
            // (R16) Input and output maps update independently
            in_sel_q <= in_sel_d;
            in_shd_q <= in_sel_d;
            out_sel_q <= out_sel_d;
            out_shd_q <= out_sel_d;
        end
    end

    // Implemented set and registered outputs
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            impl_q <= '0;
            periph_in_q <= '0;
            pin_out_q <= '0;
            pin_oe_q <= '0;
        end else begin
            impl_q <= impl_d;
            periph_in_q <= pin_in_d;
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    // Readback follows the index each cycle, so it needs no reset
    always_ff @(posedge clk_sys_in) begin
        in_rd_q <= in_rd_d;
        out_rd_q <= out_rd_d;
    end

    assign periph_in_out = periph_in_q;
    assign remap_pin_out = pin_out_q;
    assign remap_pin_oe_out = pin_oe_q;
    assign map_write_lock_out = lock_q;
    assign config_mismatch_out = mism_q;
    assign in_map_rdata_out = in_rd_q;
    assign out_map_rdata_out = out_rd_q;
endmodule
`default_nettype wire

// ---- rpps_pin_select_chk.sv ----
// Checker for the pin select block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module rpps_pin_select_chk (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic osc_ctl_wr_in,
    input wire logic [7:0] osc_ctl_wdata_in,
    input wire logic in_map_wr_in,
    input wire logic [3:0] in_map_idx_in,
    input wire logic [15:0] in_map_wdata_in,
    input wire logic out_map_wr_in,
    input wire logic map_fault_inject_in,
    input wire logic [22:0] periph_in_out,
    input wire logic [31:0] remap_pin_oe_out,
    input wire logic map_write_lock_out,
    input wire logic config_mismatch_out,
    input wire logic [15:0] in_map_rdata_out
);
    // ********
    // Properties
    // ********
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);
    logic out_wr_q;
    logic out_wr_d;
    // Sticky until reset: any output selector write seen
    always_comb out_wr_d = (out_wr_q | out_map_wr_in) & ~sys_rst_in;
    always_ff @(posedge clk_sys_in) out_wr_q <= out_wr_d;
    sequence keys_s;
        osc_ctl_wr_in && osc_ctl_wdata_in == 8'h46 ##1 osc_ctl_wr_in && osc_ctl_wdata_in == 8'h57;
    endsequence
    // Registers from 11 up hold at most one field, so they are left out
    sequence in_wr_s;
        in_map_wr_in && !map_write_lock_out && in_map_idx_in < 4'hB
        ##1 !in_map_wr_in && $stable(in_map_idx_in);
    endsequence
    reset_vals_a: assert property (disable iff (1'b0) sys_rst_in
        |=> !remap_pin_oe_out && !periph_in_out && !map_write_lock_out && !config_mismatch_out)
        else $error("outputs not cleared by reset");
    lock_set_a: assert property (keys_s ##1 osc_ctl_wr_in
        |=> map_write_lock_out == $past(osc_ctl_wdata_in[6])) else $error("lock not taken");
    lock_keys_a: assert property ($changed(map_write_lock_out) && !$past(sys_rst_in)
        |-> $past(osc_ctl_wdata_in, 3) == 8'h46 && $past(osc_ctl_wdata_in, 2) == 8'h57)
        else $error("lock changed without keys");
    locked_in_a: assert property ((map_write_lock_out && $stable(in_map_idx_in)) [*3]
        |-> $stable(in_map_rdata_out)) else $error("locked map changed");
    in_readback_a: assert property (in_wr_s
        |=> (in_map_rdata_out & 16'h3F3F) == ($past(in_map_wdata_in, 2) & 16'h3F3F))
        else $error("input selector not stored");
    out_null_a: assert property (!out_wr_q |-> remap_pin_oe_out == 32'h0000_0000)
        else $error("pin driven with null code");
    mismatch_sticky_a: assert property (config_mismatch_out |=> config_mismatch_out)
        else $error("mismatch flag dropped");
    mismatch_inject_a: assert property (map_fault_inject_in |-> ##[1:3] config_mismatch_out)
        else $error("mismatch not flagged");
endmodule
bind rpps_pin_select rpps_pin_select_chk i_rpps_pin_select_chk (.clk_sys_in, .sys_rst_in,
    .osc_ctl_wr_in, .osc_ctl_wdata_in, .in_map_wr_in, .in_map_idx_in, .in_map_wdata_in,
    .out_map_wr_in, .map_fault_inject_in, .periph_in_out, .remap_pin_oe_out,
    .map_write_lock_out, .config_mismatch_out, .in_map_rdata_out);
`default_nettype wire

// ---- rpps_pin_select_test.sv ----
// Self-checking bench of the pin select block
`timescale 1ns/1ps
`default_nettype none
module rpps_pin_select_test;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic v44 = 1'b0;
    logic owr = 1'b0;
    logic iwr = 1'b0;
    logic uwr = 1'b0;
    logic inj = 1'b0;
    logic step = 1'b0;
    logic [7:0] odat = 8'h00;
    logic [3:0] idx = 4'h0;
    logic [15:0] dat = 16'h0000;
    logic [31:0] pin, po, poe, ext;
    logic [22:0] per, pi;
    logic lock, mism;
    logic [15:0] ird, ord;
    int isel [24] = '{default: 63};
    int ocode [26] = '{default: 0};
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 6699;
    rpps_pin_select i_rpps_pin_select (.clk_sys_in, .sys_rst_in, .variant_44_in(v44),
        .osc_ctl_wr_in(owr), .osc_ctl_wdata_in(odat), .in_map_wr_in(iwr), .in_map_idx_in(idx),
        .in_map_wdata_in(dat), .out_map_wr_in(uwr), .out_map_idx_in(idx),
        .out_map_wdata_in(dat), .remap_pin_in(pin), .periph_out_in(per),
        .map_fault_inject_in(inj), .periph_in_out(pi), .remap_pin_out(po),
        .remap_pin_oe_out(poe), .map_write_lock_out(lock), .config_mismatch_out(mism),
        .in_map_rdata_out(ird), .out_map_rdata_out(ord));
    rpps_far_model i_rpps_far_model (.clk_sys_in, .step_in(step), .pin_drv_in(po),
        .pin_oe_in(poe), .pin_lvl_out(pin), .periph_lvl_out(per), .ext_lvl_out(ext));
    // ********
    // Tasks
    // ********
    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic osc3(logic [7:0] a, logic [7:0] b, logic [7:0] c);
        @(posedge clk_sys_in);
        owr <= 1'b1;
        odat <= a;
        @(posedge clk_sys_in);
        odat <= b;
        @(posedge clk_sys_in);
        odat <= c;
        @(posedge clk_sys_in);
        owr <= 1'b0;
        cyc(2);
    endtask
    // Input map packs two fields at bits 13:8 and 5:0, output map at bits 12:8 and 4:0
    task automatic wmap(logic o, int i, int lo, int hi);
        @(posedge clk_sys_in);
        iwr <= !o;
        uwr <= o;
        idx <= 4'(i);
        dat <= {2'b00, 6'(hi), 2'b00, 6'(lo)};
        @(posedge clk_sys_in);
        iwr <= 1'b0;
        uwr <= 1'b0;
    endtask
    // Locked runs leave isel and ocode as they were
    task automatic remap(bit lk);
        int r [4];
        for (int i = 0; i < 13; i++) begin
            foreach (r[j]) begin
                r[j] = {$random(seed)} % (j < 2 ? 64 : 32);
            end
            if (i < 12) wmap(1'b0, i, r[0], r[1]);
            wmap(1'b1, i, r[2], r[3]);
            if (!lk && i < 12) isel[2*i] = r[0];
            if (!lk && i < 12) isel[2*i+1] = r[1];
            if (!lk) ocode[2*i] = r[2];
            if (!lk) ocode[2*i+1] = r[3];
        end
        @(posedge clk_sys_in);
        step <= 1'b1;
        @(posedge clk_sys_in);
        step <= 1'b0;
        cyc(10);
    endtask
    task automatic check_all();
        logic [31:0] m, eoe, eout;
        logic [22:0] ein;
        logic [15:0] ei, eo;
        int b;
        m = v44 ? 32'h03FF_EFFF : 32'h0000_EFFF;
        eoe = 32'h0000_0000;
        eout = 32'h0000_0000;
        for (int p = 0; p < 26; p++) begin
            b = ocode[p];
            b = (b inside {[1:12]}) ? b - 1 : (b inside {[18:22]}) ? b - 6 :
                (b == 29) ? 17 : (b == 30) ? 18 : -1;
            eoe[p] = b >= 0 && m[p];
            if (eoe[p]) eout[p] = per[b];
        end
        for (int i = 0; i < 23; i++) begin
            b = isel[i];
            ein[i] = b < 32 && m[b] && (eoe[b] ? eout[b] : ext[b]);
        end
        chk("oe", eoe, poe);
        chk("pin", eout, po);
        chk("in", 32'(ein), 32'(pi));
        // Readback of every map register, two cycles after the index settles
        for (int k = 0; k < 16; k++) begin
            @(posedge clk_sys_in);
            idx <= 4'(k);
            cyc(2);
            ei = 16'h0000;
            eo = 16'h0000;
            if (k < 12) ei[5:0] = 6'(isel[2*k]);
            if (k < 11) ei[13:8] = 6'(isel[2*k+1]);
            if (k < 13) eo = {3'b000, 5'(ocode[2*k+1]), 3'b000, 5'(ocode[2*k])};
            chk("in_map", 32'(ei), 32'(ird));
            chk("out_map", 32'(eo), 32'(ord));
        end
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ********
    // Sequence
    // ********
    initial forever #5 clk_sys_in = ~clk_sys_in;
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        cyc(4);
        check_all();
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_sys_in);
            v44 <= k[0];
            remap(1'b0);
            check_all();
        end
        osc3(8'h46, 8'h12, 8'h40);
        chk("lock", 32'h0, 32'(lock));
        osc3(8'h46, 8'h57, 8'h40);
        chk("lock", 32'h1, 32'(lock));
        remap(1'b1);
        check_all();
        osc3(8'h46, 8'h57, 8'h00);
        chk("lock", 32'h0, 32'(lock));
        remap(1'b0);
        check_all();
        @(posedge clk_sys_in);
        inj <= 1'b1;
        @(posedge clk_sys_in);
        inj <= 1'b0;
        cyc(4);
        chk("mismatch", 32'h1, 32'(mism));
        @(posedge clk_sys_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        isel = '{default: 63};
        ocode = '{default: 0};
        cyc(4);
        check_all();
        chk("mismatch", 32'h0, 32'(mism));
        end_of_test();
    end
endmodule
`default_nettype wire

// ---- rpps_pkg.sv ----
// Constants and types for the remappable peripheral pin select block
package rpps_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_PINS = 32;
    localparam int NUM_INPUTS = 23;
    localparam int NUM_OUT_FUNCS = 32;
    localparam int IN_SEL_W = 6;
    localparam int OUT_SEL_W = 5;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [5:0] IN_SEL_RESET = 6'h3F;
    localparam logic [4:0] OUT_SEL_RESET = 5'h00;
    // ****************************************
    // Implemented pin sets per variant
    // ****************************************
    localparam logic [31:0] PINS_28 = 32'h0000_EFFF;
    localparam logic [31:0] PINS_44 = 32'h03FF_EFFF;
    // ****************************************
    // Input function indices
    // ****************************************
    localparam int IN_EXT_IRQ1 = 0;
    localparam int IN_EXT_IRQ2 = 1;
    localparam int IN_CAPTURE1 = 2;
    localparam int IN_CAPTURE5 = 6;
    localparam int IN_FAULT_A = 7;
    localparam int IN_FAULT_B = 8;
    localparam int IN_SPI1_CLK = 9;
    localparam int IN_SPI1_DATA = 10;
    localparam int IN_SPI1_SEL = 11;
    localparam int IN_SPI2_CLK = 12;
    localparam int IN_SPI2_DATA = 13;
    localparam int IN_SPI2_SEL = 14;
    localparam int IN_TIMER2_CLK = 15;
    localparam int IN_TIMER5_CLK = 18;
    localparam int IN_UART1_CTS = 19;
    localparam int IN_UART1_RX = 20;
    localparam int IN_UART2_CTS = 21;
    localparam int IN_UART2_RX = 22;
    // ****************************************
    // Output function codes
    // ****************************************
    localparam logic [4:0] FN_NULL = 5'h00;
    localparam logic [4:0] FN_CMP1 = 5'h01;
    localparam logic [4:0] FN_CMP2 = 5'h02;
    localparam logic [4:0] FN_U1TX = 5'h03;
    localparam logic [4:0] FN_U1RTS = 5'h04;
    localparam logic [4:0] FN_U2TX = 5'h05;
    localparam logic [4:0] FN_U2RTS = 5'h06;
    localparam logic [4:0] FN_SPI1_DO = 5'h07;
    localparam logic [4:0] FN_SPI1_CK = 5'h08;
    localparam logic [4:0] FN_SPI1_SS = 5'h09;
    localparam logic [4:0] FN_SPI2_DO = 5'h0A;
    localparam logic [4:0] FN_SPI2_CK = 5'h0B;
    localparam logic [4:0] FN_SPI2_SS = 5'h0C;
    localparam logic [4:0] FN_CMP_OC1 = 5'h12;
    localparam logic [4:0] FN_CTPULSE = 5'h1D;
    localparam logic [4:0] FN_CMP3 = 5'h1E;
    // ****************************************
    // Lock unlock keys
    // ****************************************
    localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
    localparam int LOCK_BIT = 6;
    // ****************************************
    // Unlock sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        UNL_IDLE = 3'b001,
        UNL_KEY1 = 3'b010,
        UNL_OPEN = 3'b100
    } rpps_unl_state_t;
endpackage
